//--- verilog/vlan_filter_defs.svh
// Purpose: constants of the VLAN tag frame filter (offsets, fields, resets, codes)
// Assumes: included by the filter package and the filter module
// Notes:   register offsets are byte addresses of 32-bit words
`ifndef VLAN_FILTER_DEFS_SVH
`define VLAN_FILTER_DEFS_SVH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define VF_ADDR_W        8
`define VF_DATA_W        32
`define VF_VID_CFG_W     10
`define VF_TAG_VID_W     12
`define VF_PCP_W         3
`define VF_IDX_W         5
`define VF_CNT_W         16

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define VF_SVC_CTRL      8'h00
`define VF_CUS_CTRL      8'h04
`define VF_STATUS        8'h08
`define VF_PASS_CNT      8'h0c
`define VF_BLOCK_CNT     8'h10

// ----------------------------------------------------------------------------
// control fields (same layout for both tags, drop-eligible bits service only)
// ----------------------------------------------------------------------------
`define VF_VID_EQ_BIT    0
`define VF_PCP_EQ_BIT    1
`define VF_DEI_EQ_BIT    2
`define VF_DEI_VAL_BIT   3
`define VF_PCP_LSB       4
`define VF_PCP_MSB       6
`define VF_VID_LSB       16
`define VF_VID_MSB       25
`define VF_ST_PASS_BIT   0
`define VF_ST_SINGLE_BIT 1
`define VF_ST_DOUBLE_BIT 2

// ----------------------------------------------------------------------------
// tag layout and frame positions
// ----------------------------------------------------------------------------
`define VF_TCI_PCP_LSB   13
`define VF_TCI_PCP_MSB   15
`define VF_TCI_DEI_BIT   12
`define VF_TCI_VID_MSB   11
`define VF_TYPE_SERVICE  16'h88a8
`define VF_TYPE_CUSTOMER 16'h8100
`define VF_TYPE_LO_IDX   5'h0d
`define VF_IDX_MAX       5'h1f

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define VF_RST_MODE      1'h0
`define VF_RST_VID       10'h000
`define VF_RST_PCP       3'h0
`define VF_RST_CNT       16'h0000

`endif

//--- verilog/vlan_filter_pkg.sv
// Purpose: types of the VLAN tag frame filter
// Assumes: constants come from vlan_filter_defs.svh
// Notes:   the whole module state is one packed struct
`include "vlan_filter_defs.svh"

package vlan_filter_pkg;

  // --------------------------------------------------------------------------
  // parse phases of one frame
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ps_hdr,
    ps_s_tci,
    ps_inner_type,
    ps_c_tci,
    ps_done
  } parse_state_t;

  // --------------------------------------------------------------------------
  // complete state of the filter
  // --------------------------------------------------------------------------
  typedef struct packed {
    parse_state_t                  ps;
    logic [`VF_IDX_W-1:0]          idx;
    logic [7:0]                    hi_byte;
    logic                          svc_seen;
    logic                          cus_seen;
    logic [`VF_PCP_W-1:0]          svc_pcp;
    logic                          svc_dei;
    logic [`VF_TAG_VID_W-1:0]      svc_vid;
    logic [`VF_PCP_W-1:0]          cus_pcp;
    logic [`VF_TAG_VID_W-1:0]      cus_vid;
    logic                          svc_vid_eq;
    logic [`VF_VID_CFG_W-1:0]      svc_vid_cfg;
    logic                          svc_pcp_eq;
    logic [`VF_PCP_W-1:0]          svc_pcp_cfg;
    logic                          svc_dei_eq;
    logic                          svc_dei_cfg;
    logic                          cus_vid_eq;
    logic [`VF_VID_CFG_W-1:0]      cus_vid_cfg;
    logic                          cus_pcp_eq;
    logic [`VF_PCP_W-1:0]          cus_pcp_cfg;
    logic [`VF_DATA_W-1:0]         rd_data;
    logic                          verdict_valid;
    logic                          verdict_pass;
    logic                          last_pass;
    logic                          last_single;
    logic                          last_double;
    logic [`VF_CNT_W-1:0]          pass_cnt;
    logic [`VF_CNT_W-1:0]          block_cnt;
  } state_t;

endpackage

//--- verilog/vlan_tag_frame_filter.sv
// Purpose: decide per received frame whether it passes the VLAN tag filter
// Assumes: byte stream and register port come from logic on the same clock
// Notes:   verdict is a one-cycle pulse in the cycle after the last byte
//
// How it works
// - frames with one tag and frames with a service tag followed by a customer tag are both parsed.
// - each tag is taken as a sixteen-bit word carrying priority, drop-eligible bit and identifier.
// - a criterion left at Ignore never selects a frame, so all-Ignore blocks every frame.
// - an identifier criterion at Equal to passes only frames whose identifier equals the setting.
// - the configured identifier is stored as ten bits.
// - service and customer identifier matching have separate, independent settings.
// - a lone tag is the customer tag; customer settings are matched against it and any service criterion at Equal to blocks it.
// - priority matching has Ignore and Equal to modes against a three-bit setting.
// - service and customer priority have separate settings; a lone tag uses the customer ones.
// - drop-eligible matching has Ignore and Equal to modes against the service tag bit.
// - the drop-eligible setting is one bit compared with the one-bit tag field.
// - drop-eligible matching exists for the service tag only, never for the customer tag.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "vlan_filter_defs.svh"

module vlan_tag_frame_filter (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst,
  // received byte stream
  input  wire logic                    rx_valid,
  input  wire logic                    rx_sof,
  input  wire logic                    rx_eof,
  input  wire logic [7:0]              rx_data,
  // register port
  input  wire logic [`VF_ADDR_W-1:0]   reg_addr,
  input  wire logic [`VF_DATA_W-1:0]   reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [`VF_DATA_W-1:0]   reg_rdata,
  // verdict
  output logic                         frame_done,
  output logic                         frame_pass
);

  vlan_filter_pkg::state_t      st_ff;
  vlan_filter_pkg::state_t      nxt_st;
  vlan_filter_pkg::parse_state_t ps_in;
  logic [`VF_IDX_W-1:0]         cur_idx;
  logic [15:0]                  word;
  logic                         any_eq;
  logic                         all_ok;
  logic                         verdict;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_st               = st_ff;
    nxt_st.verdict_valid = 1'h0;
    nxt_st.rd_data       = '0;
    ps_in                = rx_sof ? vlan_filter_pkg::ps_hdr : st_ff.ps;
    cur_idx              = rx_sof ? '0 : st_ff.idx;
    word                 = {st_ff.hi_byte, rx_data};
    any_eq               = 1'h0;
    all_ok               = 1'h1;
    verdict              = 1'h0;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        `VF_SVC_CTRL: begin
          nxt_st.svc_vid_eq  = reg_wdata[`VF_VID_EQ_BIT];
          nxt_st.svc_pcp_eq  = reg_wdata[`VF_PCP_EQ_BIT];
          nxt_st.svc_dei_eq  = reg_wdata[`VF_DEI_EQ_BIT];
          nxt_st.svc_dei_cfg = reg_wdata[`VF_DEI_VAL_BIT];
          nxt_st.svc_pcp_cfg = reg_wdata[`VF_PCP_MSB:`VF_PCP_LSB];
          nxt_st.svc_vid_cfg = reg_wdata[`VF_VID_MSB:`VF_VID_LSB];
        end
        `VF_CUS_CTRL: begin
          // no drop-eligible fields here
          nxt_st.cus_vid_eq  = reg_wdata[`VF_VID_EQ_BIT];
          nxt_st.cus_pcp_eq  = reg_wdata[`VF_PCP_EQ_BIT];
          nxt_st.cus_pcp_cfg = reg_wdata[`VF_PCP_MSB:`VF_PCP_LSB];
          nxt_st.cus_vid_cfg = reg_wdata[`VF_VID_MSB:`VF_VID_LSB];
        end
        default: begin
        end
      endcase
    end

    // register reads, answered in the next cycle only
    if (reg_rd) begin
      case (reg_addr)
        `VF_SVC_CTRL: begin
          nxt_st.rd_data[`VF_VID_EQ_BIT]           = st_ff.svc_vid_eq;
          nxt_st.rd_data[`VF_PCP_EQ_BIT]           = st_ff.svc_pcp_eq;
          nxt_st.rd_data[`VF_DEI_EQ_BIT]           = st_ff.svc_dei_eq;
          nxt_st.rd_data[`VF_DEI_VAL_BIT]          = st_ff.svc_dei_cfg;
          nxt_st.rd_data[`VF_PCP_MSB:`VF_PCP_LSB]  = st_ff.svc_pcp_cfg;
          nxt_st.rd_data[`VF_VID_MSB:`VF_VID_LSB]  = st_ff.svc_vid_cfg;
        end
        `VF_CUS_CTRL: begin
          nxt_st.rd_data[`VF_VID_EQ_BIT]           = st_ff.cus_vid_eq;
          nxt_st.rd_data[`VF_PCP_EQ_BIT]           = st_ff.cus_pcp_eq;
          nxt_st.rd_data[`VF_PCP_MSB:`VF_PCP_LSB]  = st_ff.cus_pcp_cfg;
          nxt_st.rd_data[`VF_VID_MSB:`VF_VID_LSB]  = st_ff.cus_vid_cfg;
        end
        `VF_STATUS: begin
          nxt_st.rd_data[`VF_ST_PASS_BIT]          = st_ff.last_pass;
          nxt_st.rd_data[`VF_ST_SINGLE_BIT]        = st_ff.last_single;
          nxt_st.rd_data[`VF_ST_DOUBLE_BIT]        = st_ff.last_double;
        end
        `VF_PASS_CNT: begin
          nxt_st.rd_data[`VF_CNT_W-1:0]            = st_ff.pass_cnt;
        end
        `VF_BLOCK_CNT: begin
          nxt_st.rd_data[`VF_CNT_W-1:0]            = st_ff.block_cnt;
        end
        default: begin
          nxt_st.rd_data = '0;
        end
      endcase
    end

    // frame parsing, one byte per valid cycle
    if (rx_valid) begin
      if (rx_sof) begin
        nxt_st.svc_seen = 1'h0;
        nxt_st.cus_seen = 1'h0;
      end
      nxt_st.ps  = ps_in;
      nxt_st.idx = (cur_idx == `VF_IDX_MAX) ? cur_idx : cur_idx + 5'h01;
      // tag words and type words start on even byte positions
      if (!cur_idx[0]) begin
        nxt_st.hi_byte = rx_data;
      end
      case (ps_in)
        vlan_filter_pkg::ps_hdr: begin
          if (cur_idx == `VF_TYPE_LO_IDX) begin
            if (word == `VF_TYPE_SERVICE) begin
              nxt_st.ps = vlan_filter_pkg::ps_s_tci;
            end else if (word == `VF_TYPE_CUSTOMER) begin
              nxt_st.ps = vlan_filter_pkg::ps_c_tci;
            end else begin
              nxt_st.ps = vlan_filter_pkg::ps_done;
            end
          end
        end
        vlan_filter_pkg::ps_s_tci: begin
          if (cur_idx[0]) begin
            nxt_st.svc_pcp  = word[`VF_TCI_PCP_MSB:`VF_TCI_PCP_LSB];
            nxt_st.svc_dei  = word[`VF_TCI_DEI_BIT];
            nxt_st.svc_vid  = word[`VF_TCI_VID_MSB:0];
            nxt_st.svc_seen = 1'h1;
            nxt_st.ps       = vlan_filter_pkg::ps_inner_type;
          end
        end
        vlan_filter_pkg::ps_inner_type: begin
          if (cur_idx[0]) begin
            nxt_st.ps = (word == `VF_TYPE_CUSTOMER) ? vlan_filter_pkg::ps_c_tci
                                                    : vlan_filter_pkg::ps_done;
          end
        end
        vlan_filter_pkg::ps_c_tci: begin
          if (cur_idx[0]) begin
            nxt_st.cus_pcp  = word[`VF_TCI_PCP_MSB:`VF_TCI_PCP_LSB];
            nxt_st.cus_vid  = word[`VF_TCI_VID_MSB:0];
            nxt_st.cus_seen = 1'h1;
            nxt_st.ps       = vlan_filter_pkg::ps_done;
          end
        end
        default: begin
          nxt_st.ps = vlan_filter_pkg::ps_done;
        end
      endcase

      // verdict on the last byte; a field missing from the frame never matches
      if (rx_eof) begin
        any_eq = st_ff.svc_vid_eq | st_ff.svc_pcp_eq | st_ff.svc_dei_eq
               | st_ff.cus_vid_eq | st_ff.cus_pcp_eq;
        if (st_ff.svc_vid_eq && !(nxt_st.svc_seen && nxt_st.cus_seen &&
            nxt_st.svc_vid == {2'h0, st_ff.svc_vid_cfg})) begin
          all_ok = 1'h0;
        end
        if (st_ff.svc_pcp_eq && !(nxt_st.svc_seen && nxt_st.cus_seen &&
            nxt_st.svc_pcp == st_ff.svc_pcp_cfg)) begin
          all_ok = 1'h0;
        end
        if (st_ff.svc_dei_eq && !(nxt_st.svc_seen && nxt_st.cus_seen &&
            nxt_st.svc_dei == st_ff.svc_dei_cfg)) begin
          all_ok = 1'h0;
        end
        if (st_ff.cus_vid_eq && !(nxt_st.cus_seen &&
            nxt_st.cus_vid == {2'h0, st_ff.cus_vid_cfg})) begin
          all_ok = 1'h0;
        end
        if (st_ff.cus_pcp_eq && !(nxt_st.cus_seen &&
            nxt_st.cus_pcp == st_ff.cus_pcp_cfg)) begin
          all_ok = 1'h0;
        end
        verdict              = any_eq & all_ok;
        nxt_st.verdict_valid = 1'h1;
        nxt_st.verdict_pass  = verdict;
        nxt_st.last_pass     = verdict;
        nxt_st.last_double   = nxt_st.svc_seen & nxt_st.cus_seen;
        nxt_st.last_single   = nxt_st.cus_seen & !nxt_st.svc_seen;
        if (verdict) begin
          nxt_st.pass_cnt = st_ff.pass_cnt + `VF_CNT_W'(1);
        end else begin
          nxt_st.block_cnt = st_ff.block_cnt + `VF_CNT_W'(1);
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff             <= '0;
      st_ff.ps          <= vlan_filter_pkg::ps_done;
      st_ff.svc_vid_eq  <= `VF_RST_MODE;
      st_ff.svc_pcp_eq  <= `VF_RST_MODE;
      st_ff.svc_dei_eq  <= `VF_RST_MODE;
      st_ff.cus_vid_eq  <= `VF_RST_MODE;
      st_ff.cus_pcp_eq  <= `VF_RST_MODE;
      st_ff.svc_vid_cfg <= `VF_RST_VID;
      st_ff.cus_vid_cfg <= `VF_RST_VID;
      st_ff.svc_pcp_cfg <= `VF_RST_PCP;
      st_ff.cus_pcp_cfg <= `VF_RST_PCP;
      st_ff.pass_cnt    <= `VF_RST_CNT;
      st_ff.block_cnt   <= `VF_RST_CNT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata  = st_ff.rd_data;
  assign frame_done = st_ff.verdict_valid;
  assign frame_pass = st_ff.verdict_pass;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  double_tag_parse_a: assert property (
    rx_valid && !rx_sof && st_ff.ps == vlan_filter_pkg::ps_hdr &&
    st_ff.idx == `VF_TYPE_LO_IDX && {st_ff.hi_byte, rx_data} == `VF_TYPE_SERVICE
    |=> st_ff.ps == vlan_filter_pkg::ps_s_tci)
    else $error("service type word did not start a service tag");

  tci_fields_a: assert property (
    rx_valid && !rx_sof && st_ff.ps == vlan_filter_pkg::ps_c_tci && st_ff.idx[0]
    |=> st_ff.cus_seen && st_ff.cus_vid == $past({st_ff.hi_byte[3:0], rx_data})
        && st_ff.cus_pcp == $past(st_ff.hi_byte[7:5]))
    else $error("customer tag fields not captured from the tag word");

  all_ignore_a: assert property (
    rx_valid && rx_eof && !st_ff.svc_vid_eq && !st_ff.svc_pcp_eq && !st_ff.svc_dei_eq
    && !st_ff.cus_vid_eq && !st_ff.cus_pcp_eq |=> frame_done && !frame_pass)
    else $error("frame passed with every criterion at ignore");

  vid_mismatch_a: assert property (
    frame_done && st_ff.cus_seen && $past(st_ff.cus_vid_eq) &&
    st_ff.cus_vid != {2'h0, $past(st_ff.cus_vid_cfg)} |-> !frame_pass)
    else $error("frame passed with a customer identifier mismatch");

  lone_tag_a: assert property (
    frame_done && !st_ff.svc_seen && $past(st_ff.svc_vid_eq) |-> !frame_pass)
    else $error("service settings matched a frame without a service tag");

  pcp_mismatch_a: assert property (
    frame_done && st_ff.cus_seen && $past(st_ff.cus_pcp_eq) &&
    st_ff.cus_pcp != $past(st_ff.cus_pcp_cfg) |-> !frame_pass)
    else $error("frame passed with a customer priority mismatch");

  dei_mismatch_a: assert property (
    frame_done && $past(st_ff.svc_dei_eq) &&
    st_ff.svc_dei != $past(st_ff.svc_dei_cfg) |-> !frame_pass)
    else $error("frame passed with a drop-eligible mismatch");

  cus_no_dei_a: assert property (
    reg_rd && reg_addr == `VF_CUS_CTRL
    |=> reg_rdata[`VF_DEI_EQ_BIT] == 1'h0 && reg_rdata[`VF_DEI_VAL_BIT] == 1'h0)
    else $error("customer settings show drop-eligible bits");

  pass_count_a: assert property (
    frame_done |-> (frame_pass ? st_ff.pass_cnt == $past(st_ff.pass_cnt) + 16'h0001
                               : st_ff.block_cnt == $past(st_ff.block_cnt) + 16'h0001))
    else $error("frame counters disagree with the verdict");

  vid_store_a: assert property (
    reg_wr && reg_addr == `VF_SVC_CTRL ##1 reg_rd && reg_addr == `VF_SVC_CTRL
    |=> reg_rdata[`VF_VID_MSB:`VF_VID_LSB] == $past(reg_wdata[`VF_VID_MSB:`VF_VID_LSB], 2))
    else $error("service identifier setting not held as written");

  svc_vid_mismatch_a: assert property (
    frame_done && $past(st_ff.svc_vid_eq) && st_ff.svc_vid != {2'h0, $past(st_ff.svc_vid_cfg)}
    |-> !frame_pass)
    else $error("frame passed with a service identifier mismatch");

  svc_pcp_mismatch_a: assert property (
    frame_done && $past(st_ff.svc_pcp_eq) && st_ff.svc_pcp != $past(st_ff.svc_pcp_cfg)
    |-> !frame_pass)
    else $error("frame passed with a service priority mismatch");

  svc_needs_dbl_a: assert property (
    frame_done && !(st_ff.svc_seen && st_ff.cus_seen)
    && ($past(st_ff.svc_pcp_eq) || $past(st_ff.svc_dei_eq)) |-> !frame_pass)
    else $error("service settings matched a frame that is not double-tagged");

  cus_missing_a: assert property (
    frame_done && !st_ff.cus_seen && ($past(st_ff.cus_vid_eq) || $past(st_ff.cus_pcp_eq))
    |-> !frame_pass)
    else $error("customer settings matched a frame without a customer tag");

  verdict_pulse_a: assert property (
    rx_valid && rx_eof
    |=> frame_done)
    else $error("no verdict in the cycle after the last byte");

  verdict_cause_a: assert property (
    frame_done
    |-> $past(rx_valid && rx_eof))
    else $error("verdict without a last byte");

  svc_fields_a: assert property (
    rx_valid && !rx_sof && st_ff.ps == vlan_filter_pkg::ps_s_tci && st_ff.idx[0]
    |=> st_ff.svc_seen && st_ff.svc_dei == $past(st_ff.hi_byte[4])
        && st_ff.svc_vid == $past({st_ff.hi_byte[3:0], rx_data}))
    else $error("service tag fields not captured from the tag word");

  dei_store_a: assert property (
    reg_wr && reg_addr == `VF_SVC_CTRL
    |=> st_ff.svc_dei_eq == $past(reg_wdata[`VF_DEI_EQ_BIT])
        && st_ff.svc_dei_cfg == $past(reg_wdata[`VF_DEI_VAL_BIT]))
    else $error("drop-eligible settings not held as written");

  cus_store_a: assert property (
    reg_wr && reg_addr == `VF_CUS_CTRL
    |=> st_ff.cus_vid_cfg == $past(reg_wdata[`VF_VID_MSB:`VF_VID_LSB])
        && st_ff.cus_pcp_cfg == $past(reg_wdata[`VF_PCP_MSB:`VF_PCP_LSB]))
    else $error("customer settings not held as written");

endmodule // vlan_tag_frame_filter

//--- verification/vlan_frame_source.sv
// Purpose: byte source standing in for the network under test
// Assumes: the bench calls send and idle; bytes change just after a rising edge
// Notes:   idle data toggles so a stale byte never looks like a held one
`timescale 1ns/100ps

module vlan_frame_source (
  // clock
  input  wire logic       clock,
  // received byte stream
  output logic            rx_valid,
  output logic            rx_sof,
  output logic            rx_eof,
  output logic [7:0]      rx_data
);
  initial begin
    rx_valid = 1'b0;
    rx_sof   = 1'b0;
    rx_eof   = 1'b0;
    rx_data  = 8'h5a;
  end

  // ---------------------------------------------------------------------
  // frame driver
  // ---------------------------------------------------------------------
  // w holds four big-endian words at bytes 12..19; cut drops the end mark
  task automatic send(input logic [15:0] w [4], input int len, input bit slow,
                      input bit cut);
    logic [7:0] b;
    for (int i = 0; i < len; i++) begin
      b = (i >= 12 && i < 20) ? (i[0] ? w[(i-12)/2][7:0] : w[(i-12)/2][15:8])
                              : 8'($urandom);
      if (slow && i > 0 && $urandom_range(3) == 0) begin
        @(posedge clock);
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;
      end
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_sof   <= (i == 0);
      rx_eof   <= (i == len - 1) && !cut;
      rx_data  <= b;
    end
  endtask

  task automatic idle();
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_sof   <= 1'b0;
    rx_eof   <= 1'b0;
    rx_data  <= ~rx_data;
  endtask
endmodule // vlan_frame_source

//--- verification/vlan_tag_frame_filter_bench.sv
// Purpose: self-checking bench of the VLAN tag frame filter
// Assumes: expectations queued by the drivers, popped by the monitor
// Notes:   configs copy frame fields most of the time so passes really occur
`timescale 1ns/100ps
`include "vlan_filter_defs.svh"

module vlan_tag_frame_filter_bench;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        rx_valid, rx_sof, rx_eof;
  logic [7:0]  rx_data;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        frame_done, frame_pass;
  logic [31:0] rq[$];
  logic        vq[$];
  logic [31:0] s_cfg, c_cfg, st;
  logic [15:0] pcnt = 16'h0, bcnt = 16'h0;
  bit          rd_flag = 1'b0, use_eq;
  int          miscompares = 0, total_checks = 0;

  always #20 clock = ~clock;

  vlan_tag_frame_filter u_dut (.clock(clock), .rst(rst), .rx_valid(rx_valid),
    .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_done(frame_done), .frame_pass(frame_pass));

  vlan_frame_source src (.clock(clock), .rx_valid(rx_valid), .rx_sof(rx_sof),
    .rx_eof(rx_eof), .rx_data(rx_data));

  // ---------------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clock);
    reg_addr <= a;
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
  endtask

  task automatic bus_idle();
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_wdata <= 32'($urandom);
  endtask

  // ---------------------------------------------------------------------
  // reference verdict
  // ---------------------------------------------------------------------
  function automatic logic exp_pass(input logic [31:0] s, input logic [31:0] c,
                                    input logic [15:0] w [4], input int len);
    logic        dbl, cp, ok;
    logic [15:0] ct;
    dbl = w[0] == `VF_TYPE_SERVICE && w[2] == `VF_TYPE_CUSTOMER && len >= 20;
    cp  = dbl || (w[0] == `VF_TYPE_CUSTOMER && len >= 16);
    ct  = dbl ? w[3] : w[1];
    ok  = 1'b1;
    if (s[0]) ok &= dbl && w[1][11:0] == {2'h0, s[25:16]};
    if (s[1]) ok &= dbl && w[1][15:13] == s[6:4];
    if (s[2]) ok &= dbl && w[1][12] == s[3];
    if (c[0]) ok &= cp && ct[11:0] == {2'h0, c[25:16]};
    if (c[1]) ok &= cp && ct[15:13] == c[6:4];
    return ok && (s[0] | s[1] | s[2] | c[0] | c[1]);
  endfunction

  // kind: 0 untagged, 1 single, 2 double, 3 lone service tag, 4 truncated double
  task automatic one_frame(input int kind, input bit slow, input bit cut,
                           input bit newcfg, input bit rd);
    logic [15:0] w [4];
    logic [15:0] ct;
    int          len;
    logic        p;
    w[0] = kind == 0 ? 16'h0800 : kind == 1 ? `VF_TYPE_CUSTOMER : `VF_TYPE_SERVICE;
    w[1] = 16'($urandom);
    w[2] = kind == 3 ? 16'h0800 : `VF_TYPE_CUSTOMER;
    w[3] = 16'($urandom);
    len  = kind == 4 ? 17 : 20 + $urandom_range(40);
    if ($urandom_range(1)) w[1][11:10] = 2'h0;
    if ($urandom_range(1)) w[3][11:10] = 2'h0;
    ct = kind == 1 ? w[1] : w[3];
    if (newcfg) begin
      s_cfg = $urandom;
      c_cfg = $urandom;
      if ($urandom_range(3) != 0) {s_cfg[25:16], s_cfg[6:3]} = {w[1][9:0], w[1][15:12]};
      if ($urandom_range(3) != 0) {c_cfg[25:16], c_cfg[6:4]} = {ct[9:0], ct[15:13]};
      if (!use_eq) begin
        s_cfg[2:0] = 3'h0;
        c_cfg[1:0] = 2'h0;
      end
      reg_write(8'h00, s_cfg);
      reg_write(8'h04, c_cfg);
      bus_idle();
    end
    p = exp_pass(s_cfg, c_cfg, w, len);
    if (!cut) begin
      vq.push_back(p);
      if (p) pcnt++;
      else bcnt++;
      st = {29'h0, w[0] == `VF_TYPE_SERVICE && w[2] == `VF_TYPE_CUSTOMER && len >= 20,
            w[0] == `VF_TYPE_CUSTOMER && len >= 16, p};
    end
    src.send(w, len, slow, cut);
    if (rd) begin
      src.idle();
      reg_read(8'h08, st);
      reg_read(8'h0c, {16'h0, pcnt});
      reg_read(8'h10, {16'h0, bcnt});
      bus_idle();
    end
  endtask

  // ---------------------------------------------------------------------
  // monitor: pops the oldest note whenever a result appears
  // ---------------------------------------------------------------------
  always @(posedge clock) begin
    if (rd_flag)
      check(reg_rdata, rq.pop_front());
    else if (!rst)
      check(reg_rdata, 32'h0);
    rd_flag = reg_rd && !rst;
    if (!rst && frame_done !== 1'b0) begin
      if (vq.size() == 0)
        check(32'h1, 32'h0);
      else
        check({31'h0, frame_pass}, {31'h0, vq.pop_front()});
    end
  end

  initial begin
    repeat (40000) @(posedge clock);
    miscompares++;
    end_sim();
  end

  initial begin
    void'($urandom(27376));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a < 6; a++) reg_read(8'(a * 4), 32'h0);
    // all-ones writes show which bits exist; read-only and unmapped writes vanish
    reg_write(8'h00, 32'hffffffff);
    reg_write(8'h04, 32'hffffffff);
    reg_write(8'h08, 32'hffffffff);
    reg_write(8'h14, 32'hffffffff);
    reg_read(8'h00, 32'h03ff007f);
    reg_read(8'h04, 32'h03ff0073);
    reg_read(8'h08, 32'h0);
    reg_read(8'h14, 32'h0);
    // write then read back at once, so the stored identifier is seen straight away
    reg_write(8'h00, 32'h0155002a);
    reg_read(8'h00, 32'h0155002a);
    bus_idle();
    use_eq = 1'b0;
    for (int k = 0; k < 5; k++) one_frame(k, 1'b0, 1'b0, 1'b1, 1'b1);
    use_eq = 1'b1;
    for (int i = 0; i < 100; i++) one_frame(i % 5, i[0], 1'b0, 1'b1, 1'b1);
    // aborted frame restarted by a new start, then frames with no gap between
    one_frame(2, 1'b0, 1'b1, 1'b1, 1'b0);
    one_frame(1, 1'b0, 1'b0, 1'b0, 1'b0);
    one_frame(2, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (5) @(posedge clock);
    check(32'(rq.size() + vq.size()), 32'h0);
    end_sim();
  end
endmodule // vlan_tag_frame_filter_bench
